// ===== verilog/lfo_regs.sv
// lane fifo fault flags, fault summary and core-0 offset trim registers
// assumes classic wishbone master, fault inputs and calibration state synchronous to clk_sys
// Function
// - one sticky fault flag per lane
// - write one clears lane flag
// - persistent fault sets flag again immediately
// - summary write-one clears all lane flags
// - lane flags reset to all ones
// - trim bits 11:0 drive core 0 offset
// - trim resets zero, fuse value loaded after
// - spare cores still offset-calibrated in foreground
// - summary set on any active lane fault, w1c
// - lane flags and summary bit reset to one, block event bit resets to zero
module lfo_regs (
   input  wire logic                          clk_sys,
   input  wire logic                          reset_n,
   input  wire logic                          wb_cyc_i,
   input  wire logic                          wb_stb_i,
   input  wire logic                          wb_we_i,
   input  wire logic [13:0]                   wb_adr_i,
   input  wire logic [3:0]                    wb_sel_i,
   input  wire logic [lfo_pkg::DAT_W-1:0]     wb_dat_i,
   output logic      [lfo_pkg::DAT_W-1:0]     wb_dat_o,
   output logic                               wb_ack_o,
   output logic                               wb_err_o,
   input  wire logic [lfo_pkg::NUM_LANES-1:0] lane_fault,
   input  wire logic [lfo_pkg::NUM_LANES-1:0] lane_active,
   input  wire logic                          offset_calib_on,
   input  wire logic                          bg_calib_on,
   input  wire logic                          bg_offset_calib_on,
   input  wire logic                          foreground_calib_complete,
   input  wire logic                          fuse_load,
   input  wire logic [lfo_pkg::TRIM_W-1:0]    fuse_trim,
   output logic      [lfo_pkg::TRIM_W-1:0]    converter_core0_offset,
   output logic                               spare_offset_calib_en,
   output logic                               irq
);
   import lfo_pkg::*;

   logic [NUM_LANES-1:0] lane_flags;
   logic [OFS_REG_W-1:0] trim_reg;
   logic                 summary_reg;
   logic                 block_evt_reg;
   logic [1:0]           irq_mask_reg;
   logic                 req;
   logic                 wr;
   logic                 hit_lane;
   logic                 hit_trim;
   logic                 hit_sum;
   logic                 hit_mask;
   logic                 hit_stat;
   logic                 trim_blocked;
   logic                 sum_clear;
   logic [DAT_W-1:0]     rdata_next;

   // new request only while ack is low, so each cycle is answered once
   assign req = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
   assign wr  = req && wb_we_i;

   always_comb begin
      hit_lane = 1'b0;
      hit_trim = 1'b0;
      hit_sum  = 1'b0;
      hit_mask = 1'b0;
      hit_stat = 1'b0;
      if (wb_adr_i == ADR_LANE_FLAGS) begin
         hit_lane = 1'b1;
      end else if (wb_adr_i == ADR_CORE0_TRIM) begin
         hit_trim = 1'b1;
      end else if (wb_adr_i == ADR_SUMMARY) begin
         hit_sum = 1'b1;
      end else if (wb_adr_i == ADR_IRQ_MASK) begin
         hit_mask = 1'b1;
      end else if (wb_adr_i == ADR_CALIB_STAT) begin
         hit_stat = 1'b1;
      end
   end

   // trim is off limits while offset calibration runs: foreground until done,
   // or always when background offset calibration is on
   always_comb begin
      if (offset_calib_on && !(bg_calib_on && bg_offset_calib_on)) begin
         trim_blocked = !foreground_calib_complete;
      end else if (bg_calib_on && bg_offset_calib_on) begin
         trim_blocked = 1'b1;
      end else begin
         trim_blocked = 1'b0;
      end
   end

   assign sum_clear = wr && hit_sum && wb_sel_i[0] && wb_dat_i[SUM_BIT];

   lfo_lane_flags u_flags (
      .clk_sys    (clk_sys),
      .reset_n    (reset_n),
      .lane_fault (lane_fault),
      .clear_bits (wr && hit_lane && wb_sel_i[0] ? wb_dat_i[NUM_LANES-1:0] : '0),
      .clear_all  (sum_clear),
      .flags      (lane_flags)
   );

   // summary flag: any active lane fault
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         summary_reg <= 1'b1;
      end else if (|(lane_fault & lane_active)) begin
         summary_reg <= 1'b1;
      end else if (sum_clear) begin
         summary_reg <= 1'b0;
      end
   end

   // sticky event: software touched trim while it was off limits
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         block_evt_reg <= 1'b0;
      end else if (req && hit_trim && trim_blocked) begin
         block_evt_reg <= 1'b1;
      end else if (wr && hit_sum && wb_sel_i[0] && wb_dat_i[BLOCK_BIT]) begin
         block_evt_reg <= 1'b0;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         irq_mask_reg <= IRQ_MASK_RST;
      end else if (wr && hit_mask && wb_sel_i[0]) begin
         irq_mask_reg <= wb_dat_i[1:0];
      end
   end

   // offset trim: zero at reset, fuse default loaded after, writes ignored while blocked
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         trim_reg <= TRIM_RST;
      end else if (fuse_load) begin
         trim_reg <= {4'h0, fuse_trim};
      end else if (wr && hit_trim && !trim_blocked) begin
         if (wb_sel_i[0]) begin
            trim_reg[7:0] <= wb_dat_i[7:0];
         end
         if (wb_sel_i[1]) begin
            trim_reg[RSV_HI:8] <= wb_dat_i[RSV_HI:8];              // stored as written
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         converter_core0_offset <= TRIM_RST[TRIM_HI:0];
      end else begin
         converter_core0_offset <= trim_reg[TRIM_HI:0];
      end
   end

   // spare cores get offset calibration while offset calibration is on and foreground calibration is not complete, background offset or not
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         spare_offset_calib_en <= 1'b0;
      end else begin
         spare_offset_calib_en <= offset_calib_on && !foreground_calib_complete;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         irq <= 1'b0;
      end else begin
         irq <= (summary_reg & ~irq_mask_reg[SUM_BIT]) | (block_evt_reg & ~irq_mask_reg[BLOCK_BIT]);
      end
   end

   always_comb begin
      rdata_next = '0;
      if (hit_lane) begin
         rdata_next[NUM_LANES-1:0] = lane_flags;
      end else if (hit_trim) begin
         rdata_next[OFS_REG_W-1:0] = trim_blocked ? '0 : trim_reg;
      end else if (hit_sum) begin
         rdata_next[SUM_BIT]   = summary_reg;
         rdata_next[BLOCK_BIT] = block_evt_reg;
      end else if (hit_mask) begin
         rdata_next[1:0] = irq_mask_reg;
      end else if (hit_stat) begin
         rdata_next[0] = trim_blocked;
      end
   end

   // one wait state: answer in the cycle after the request is seen
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         wb_ack_o <= 1'b0;
         wb_err_o <= 1'b0;
         wb_dat_o <= '0;
      end else begin
         wb_ack_o <= req && (hit_lane || hit_trim || hit_sum || hit_mask || hit_stat);
         wb_err_o <= req && !(hit_lane || hit_trim || hit_sum || hit_mask || hit_stat);
         wb_dat_o <= (req && !wb_we_i) ? rdata_next : '0;
      end
   end
endmodule

// ===== verilog/lfo_pkg.sv
// package for the lane fifo fault and offset trim register slice
// assumes a 32-bit classic wishbone bus with byte addresses
package lfo_pkg;
   localparam int          NUM_LANES        = 8;
   localparam int          TRIM_W           = 12;
   localparam int          OFS_REG_W        = 16;
   localparam int          ADR_W            = 12;
   localparam int          DAT_W            = 32;
   // printed offsets are not all multiples of four: index, byte address is 4x
   localparam logic [11:0] IDX_LANE_FLAGS   = 12'h2c4;
   localparam logic [11:0] IDX_CORE0_TRIM   = 12'h330;
   localparam logic [11:0] IDX_SUMMARY      = 12'h2c1;
   localparam logic [11:0] IDX_IRQ_MASK     = 12'h2c2;
   localparam logic [11:0] IDX_CALIB_STAT   = 12'h3f0;
   localparam logic [13:0] ADR_LANE_FLAGS   = {IDX_LANE_FLAGS, 2'b00};
   localparam logic [13:0] ADR_CORE0_TRIM   = {IDX_CORE0_TRIM, 2'b00};
   localparam logic [13:0] ADR_SUMMARY      = {IDX_SUMMARY, 2'b00};
   localparam logic [13:0] ADR_IRQ_MASK     = {IDX_IRQ_MASK, 2'b00};
   localparam logic [13:0] ADR_CALIB_STAT   = {IDX_CALIB_STAT, 2'b00};
   localparam logic [7:0]  LANE_FLAGS_RST   = 8'hff;
   localparam logic [15:0] TRIM_RST         = 16'h0000;
   localparam logic [1:0]  IRQ_MASK_RST     = 2'b11;
   // status and trim field bit positions
   localparam int          SUM_BIT          = 0;
   localparam int          BLOCK_BIT        = 1;
   localparam int          TRIM_HI          = 11;
   localparam int          RSV_HI           = 15;
   localparam int          RSV_LO           = 12;
endpackage

// ===== verilog/lfo_lane_flags.sv
// per-lane sticky fifo fault flags with write-one clear and bulk clear
// assumes fault pulses synchronous to clk_sys
module lfo_lane_flags (
   input  wire logic                          clk_sys,
   input  wire logic                          reset_n,
   input  wire logic [lfo_pkg::NUM_LANES-1:0] lane_fault,
   input  wire logic [lfo_pkg::NUM_LANES-1:0] clear_bits,
   input  wire logic                          clear_all,
   output logic      [lfo_pkg::NUM_LANES-1:0] flags
);
   import lfo_pkg::*;
   for (genvar i = 0; i < NUM_LANES; i++) begin : g_lane
      always_ff @(posedge clk_sys) begin
         if (!reset_n) begin
            flags[i] <= LANE_FLAGS_RST[i];
         end else if (lane_fault[i]) begin
            flags[i] <= 1'b1;
         end else if (clear_bits[i] || clear_all) begin
            flags[i] <= 1'b0;
         end
      end
   end
endmodule

// ===== tb/lfo_regs_checker.sv
// assertions on the lfo_regs ports: bus answer, trim and fuse paths, spare calibration
// assumes it is bound to lfo_regs and sees only its ports
module lfo_regs_checker (
   input wire logic                       clk_sys,
   input wire logic                       reset_n,
   input wire logic                       wb_cyc_i,
   input wire logic                       wb_stb_i,
   input wire logic                       wb_we_i,
   input wire logic [13:0]                wb_adr_i,
   input wire logic [3:0]                 wb_sel_i,
   input wire logic [lfo_pkg::DAT_W-1:0]  wb_dat_i,
   input wire logic [lfo_pkg::DAT_W-1:0]  wb_dat_o,
   input wire logic                       wb_ack_o,
   input wire logic                       wb_err_o,
   input wire logic                       offset_calib_on,
   input wire logic                       bg_calib_on,
   input wire logic                       bg_offset_calib_on,
   input wire logic                       foreground_calib_complete,
   input wire logic                       fuse_load,
   input wire logic                       spare_offset_calib_en,
   input wire logic [lfo_pkg::TRIM_W-1:0] fuse_trim,
   input wire logic [lfo_pkg::TRIM_W-1:0] converter_core0_offset
);
   import lfo_pkg::*;
   logic take, blk, trim;
   assign take = wb_cyc_i & wb_stb_i & !wb_ack_o & !wb_err_o;
   assign blk  = (offset_calib_on & !(bg_calib_on & bg_offset_calib_on) & !foreground_calib_complete)
                 | (bg_calib_on & bg_offset_calib_on);
   assign trim = take & (wb_adr_i == ADR_CORE0_TRIM);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!reset_n);
   AST_ANSWER: assert property (take |=> wb_ack_o | wb_err_o) else $error("no answer after request");
   AST_PULSE: assert property (wb_ack_o |=> !wb_ack_o && !wb_err_o) else $error("ack longer than one cycle");
   AST_IDLE: assert property (!(wb_cyc_i & wb_stb_i) |=> !wb_ack_o && !wb_err_o) else $error("answer without request");
   AST_QUIET: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("read data outside ack");
   AST_TRIM_WR: assert property (trim & wb_we_i & !blk & (wb_sel_i[1:0] == 2'b11) & !fuse_load
      |=> ##1 converter_core0_offset == $past(wb_dat_i[TRIM_HI:0], 2)) else $error("trim not applied");
   AST_FUSE: assert property (fuse_load & !(trim & wb_we_i)
      |=> ##1 converter_core0_offset == $past(fuse_trim, 2)) else $error("fuse trim not applied");
   AST_BLK_READ: assert property (trim & !wb_we_i & blk |=> wb_ack_o && wb_dat_o == 32'h0)
      else $error("blocked trim read not zero");
   AST_SPARE: assert property ($past(reset_n) |-> spare_offset_calib_en
      == $past(offset_calib_on & !foreground_calib_complete)) else $error("spare calibration enable wrong");
   cover property (trim & wb_we_i & !blk);
   cover property (trim & blk);
   cover property (wb_err_o);
endmodule

bind lfo_regs lfo_regs_checker i_lfo_regs_checker (.*);

// ===== tb/lfo_regs_tb.sv
// self-checking bench for lfo_regs through classic wishbone cycles
// assumes the checker is bound from its own file
module lfo_regs_tb;
   timeunit 1ns;
   timeprecision 1ns;
   import lfo_pkg::*;
   logic clk_sys = 1'b0, reset_n = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, fuse_load = 1'b0;
   logic offset_calib_on = 1'b0, bg_calib_on = 1'b0, bg_offset_calib_on = 1'b0, foreground_calib_complete = 1'b0;
   logic [13:0]       wb_adr_i = 14'h0000;
   logic [3:0]        wb_sel_i = 4'hf;
   logic [DAT_W-1:0]  wb_dat_i = 32'h0, wb_dat_o, q;
   logic [7:0]        lane_fault = 8'h00, lane_active = 8'hff;
   logic [TRIM_W-1:0] fuse_trim = 12'h000, converter_core0_offset;
   logic              wb_ack_o, wb_err_o, spare_offset_calib_en, irq, er;
   int                n_fail = 0, total_checks = 0;
   lfo_regs i_lfo_regs (.*);
   initial forever #50 clk_sys = ~clk_sys;
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      total_checks++;
      if (s !== e) begin
         n_fail++;
         $display("CHECK FAILED at %0t seen %h expected %h", $time, s, e);
      end
   endtask
   // one classic cycle; ack and data taken at the rising edge that sees ack, request released there
   task automatic wb(input logic we, input logic [13:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_sys);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= we;
      wb_adr_i <= a;
      wb_sel_i <= 4'hf;
      wb_dat_i <= d;
      do begin
         @(posedge clk_sys);
         n++;
      end while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1 && n < 20);
      if (n >= 20) n_fail++;
      q = wb_dat_o;
      er = wb_err_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
   endtask
   task automatic rd(input logic [13:0] a, input logic [31:0] e);
      wb(1'b0, a, 32'h0);
      chk(q, e);
   endtask
   task automatic finish_test;
      $display("checks %0d failures %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   initial begin
      #200000;
      n_fail++;
      finish_test;
   end
   initial begin
      repeat (20) @(posedge clk_sys);
      reset_n <= 1'b1;
      rd(ADR_LANE_FLAGS, 32'hff);
      rd(ADR_CORE0_TRIM, 32'h0);
      rd(ADR_SUMMARY, 32'h1);
      chk(irq, 1'b0);
      $display("test reset done");
      wb(1'b1, ADR_LANE_FLAGS, 32'h0f);
      rd(ADR_LANE_FLAGS, 32'hf0);
      wb(1'b1, ADR_SUMMARY, 32'h1);
      rd(ADR_LANE_FLAGS, 32'h0);
      rd(ADR_SUMMARY, 32'h0);
      @(posedge clk_sys);
      lane_fault <= 8'h08;
      @(posedge clk_sys);
      lane_fault <= 8'h20;
      rd(ADR_LANE_FLAGS, 32'h28);
      rd(ADR_SUMMARY, 32'h1);
      wb(1'b1, ADR_LANE_FLAGS, 32'hff);
      rd(ADR_LANE_FLAGS, 32'h20);
      lane_fault <= 8'h00;
      lane_active <= 8'hdf;
      wb(1'b1, ADR_SUMMARY, 32'h1);
      lane_fault <= 8'h20;
      rd(ADR_SUMMARY, 32'h0);
      rd(ADR_LANE_FLAGS, 32'h20);
      lane_fault <= 8'h00;
      lane_active <= 8'hff;
      $display("test fault flags done");
      wb(1'b1, ADR_SUMMARY, 32'h3);
      wb(1'b1, ADR_CORE0_TRIM, 32'h0abc);
      rd(ADR_CORE0_TRIM, 32'h0abc);
      chk(converter_core0_offset, 12'habc);
      fuse_trim <= 12'h123;
      fuse_load <= 1'b1;
      @(posedge clk_sys);
      fuse_load <= 1'b0;
      rd(ADR_CORE0_TRIM, 32'h0123);
      chk(converter_core0_offset, 12'h123);
      $display("test trim done");
      offset_calib_on <= 1'b1;
      wb(1'b1, ADR_CORE0_TRIM, 32'h0555);
      rd(ADR_CORE0_TRIM, 32'h0);
      rd(ADR_SUMMARY, 32'h2);
      chk(spare_offset_calib_en, 1'b1);
      wb(1'b1, ADR_IRQ_MASK, 32'h0);
      repeat (2) @(posedge clk_sys);
      chk(irq, 1'b1);
      wb(1'b1, ADR_SUMMARY, 32'h2);
      repeat (2) @(posedge clk_sys);
      chk(irq, 1'b0);
      foreground_calib_complete <= 1'b1;
      rd(ADR_CORE0_TRIM, 32'h0123);
      bg_calib_on <= 1'b1;
      rd(ADR_CORE0_TRIM, 32'h0123);
      bg_offset_calib_on <= 1'b1;
      rd(ADR_CORE0_TRIM, 32'h0);
      wb(1'b0, 14'h0004, 32'h0);
      chk(er, 1'b1);
      $display("test calibration gating done");
      finish_test;
   end
endmodule
